// File: verilog/ccm_consts.svh
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register word offsets (byte addresses on the bus)
// ----------------------------------------------------------------------------
`define CCM_OFF_CTRL 8'h00
`define CCM_OFF_COUNT 8'h04
`define CCM_OFF_TEMP_CUR 8'h08
`define CCM_OFF_TEMP_PRE 8'h0C
`define CCM_OFF_REQUEST 8'h10
`define CCM_OFF_STATUS 8'h14
`define CCM_OFF_HOLD 8'h18
`define CCM_OFF_ENTRY_SEL 8'h1C
`define CCM_OFF_ENTRY_A 8'h20
`define CCM_OFF_ENTRY_B 8'h24
`define CCM_OFF_INC_SET 8'h28
`define CCM_OFF_INC_RST 8'h2C
`define CCM_OFF_DEC_SET 8'h30
`define CCM_OFF_DEC_RST 8'h34

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCM_CTRL_MODE_BIT 0
`define CCM_CTRL_NUM_LSB 4
`define CCM_CTRL_NUM_MSB 8
`define CCM_CTRL_OUT0_LSB 12
`define CCM_CTRL_OUT0_MSB 13
`define CCM_CTRL_OUT1_LSB 14
`define CCM_CTRL_OUT1_MSB 15
`define CCM_REQ_CUR_BIT 0
`define CCM_REQ_PRE_BIT 1
`define CCM_STAT_OUT0_BIT 16
`define CCM_STAT_OUT1_BIT 17

// ----------------------------------------------------------------------------
// Encodings, limits and reset values
// ----------------------------------------------------------------------------
`define CCM_OUTSEL_NONE 2'h0
`define CCM_OUTSEL_FLAG0 2'h1
`define CCM_OUTSEL_FLAG1 2'h2
`define CCM_NUM_ENTRIES 16
`define CCM_NUM_RESET 5'h10
`define CCM_HOLD_MAX_MS 10'h3E8
`define CCM_RST_WORD 32'h0000_0000
`define CCM_RST_FLAGS 16'h0000
`define CCM_RST_HOLD 10'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCM_CLK_HZ 40000000
`define CCM_MS_PER_S 1000
`define CCM_MS_CYCLES (`CCM_CLK_HZ / `CCM_MS_PER_S)

`endif

// File: verilog/ccm_pkg.sv
`default_nettype none

package ccm_pkg;

    // Comparison method of the channel.
    typedef enum logic {
        MODE_TARGET,
        MODE_BAND
    } cmp_mode_e;

    // One comparison entry: target (or band lower/upper) and four action patterns.
    typedef struct packed {
        logic [31:0] val_a;
        logic [31:0] val_b;
        logic [15:0] inc_set;
        logic [15:0] inc_rst;
        logic [15:0] dec_set;
        logic [15:0] dec_rst;
    } entry_s;

    // Whole state of the comparison block.
    typedef struct packed {
        entry_s [15:0] entries;
        cmp_mode_e mode;
        logic [4:0] num_used;
        logic [1:0] out0_sel;
        logic [1:0] out1_sel;
        logic [9:0] hold_ms;
        logic [3:0] entry_sel;
        logic [31:0] count;
        logic [31:0] preset;
        logic [31:0] temp_cur;
        logic [31:0] temp_pre;
        logic [15:0] flags;
        logic step_seen;
        logic step_up;
        logic src0;
        logic src1;
        logic [31:0] ms_div;
        logic ms_tick;
        logic ack;
        logic [31:0] rdata;
    } ccm_state_s;

    // State of one external output hold stage.
    typedef struct packed {
        logic out;
        logic [9:0] remain;
    } hold_state_s;

endpackage

`default_nettype wire

// File: verilog/output_hold.sv
`include "ccm_consts.svh"
`default_nettype none

// Stretches an external output: it follows its source and, when enabled,
// stays ON for the programmed number of milliseconds after the source drops.
module output_hold
    import ccm_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ms_tick,
    input wire logic src,
    input wire logic hold_en,
    input wire logic [9:0] hold_ms,
    output logic out
);

    hold_state_s st;
    hold_state_s next_st;

    // --------------------------------------------------------------------
    // Hold countdown
    // --------------------------------------------------------------------
    // The countdown is reloaded while the source is ON, so the hold time is
    // measured from the falling edge, with a granularity of one millisecond tick.
    always_comb
    begin
        next_st = st;
        if (src)
        begin
            next_st.out = 1'b1;
            next_st.remain = hold_en ? hold_ms : `CCM_RST_HOLD;
        end
        else if (hold_en && st.remain != `CCM_RST_HOLD)
        begin
            next_st.out = 1'b1;
            if (ms_tick)
            begin
                next_st.remain = st.remain - 10'h001;
            end
        end
        else
        begin
            next_st.out = 1'b0;
            next_st.remain = `CCM_RST_HOLD;
        end
    end

    // Registered state.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign out = st.out;

endmodule

`default_nettype wire

// File: verilog/counter_compare_match.sv
`include "ccm_consts.svh"
`default_nettype none

module counter_compare_match
    import ccm_pkg::*;
#(
    parameter int MS_CYCLES = `CCM_MS_CYCLES
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_step,
    input wire logic count_up,
    input wire logic preset_load,
    output logic [31:0] live_counter_value,
    output logic [15:0] match_flags,
    output logic ext_out0,
    output logic ext_out1
);

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    ccm_state_s st;
    ccm_state_s next_st;
    logic bus_req;
    logic bus_wr;
    logic hold_en;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Merges bus write data into a word under the byte enables.
    function automatic logic [31:0] merge_sel(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Applies one set/reset pattern pair to the flags; reset beats set per bit.
    function automatic logic [15:0] apply_pat(input logic [15:0] flags, input logic [15:0] set_p,
                                              input logic [15:0] rst_p);
        return (flags | set_p) & ~rst_p;
    endfunction

    // Signed band test with both limits inclusive.
    function automatic logic in_band(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    endfunction

    // Picks flag 0 or flag 1 for an external output; anything else is not output.
    function automatic logic out_src(input logic [1:0] sel, input logic [15:0] flags);
        logic res;
        res = 1'b0;
        case (sel)
            `CCM_OUTSEL_FLAG0: res = flags[0];
            `CCM_OUTSEL_FLAG1: res = flags[1];
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // A request is acted on in the cycle the ack is raised, so each access
    // takes effect exactly once even though the master holds it for two edges.
    assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    assign bus_wr = bus_req && wb_we_i;
    assign hold_en = (st.mode == MODE_BAND);

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic [15:0] fl;
        logic [31:0] rd;
        logic [3:0] ix;
        next_st = st;
        fl = st.flags;
        rd = `CCM_RST_WORD;
        ix = st.entry_sel;

        // Bus handshake: one wait state, ack dropped the cycle after it is given.
        next_st.ack = bus_req;

        // Register writes. The count register is deliberately absent here.
        if (bus_wr)
        begin
            case (wb_adr_i)
                `CCM_OFF_CTRL:
                begin
                    if (wb_sel_i[0])
                    begin
                        next_st.mode = cmp_mode_e'(wb_dat_i[`CCM_CTRL_MODE_BIT]);
                    end
                    if (wb_sel_i[1] || wb_sel_i[0])
                    begin
                        next_st.num_used = (wb_dat_i[`CCM_CTRL_NUM_MSB:`CCM_CTRL_NUM_LSB] > `CCM_NUM_RESET) ?
                            `CCM_NUM_RESET : wb_dat_i[`CCM_CTRL_NUM_MSB:`CCM_CTRL_NUM_LSB];
                    end
                    if (wb_sel_i[1])
                    begin
                        next_st.out0_sel = wb_dat_i[`CCM_CTRL_OUT0_MSB:`CCM_CTRL_OUT0_LSB];
                        next_st.out1_sel = wb_dat_i[`CCM_CTRL_OUT1_MSB:`CCM_CTRL_OUT1_LSB];
                    end
                end
                `CCM_OFF_TEMP_CUR: next_st.temp_cur = merge_sel(st.temp_cur, wb_dat_i, wb_sel_i);
                `CCM_OFF_TEMP_PRE: next_st.temp_pre = merge_sel(st.temp_pre, wb_dat_i, wb_sel_i);
                `CCM_OFF_HOLD:
                begin
                    // Values above the documented maximum are clipped rather than wrapped.
                    next_st.hold_ms = (wb_dat_i[9:0] > `CCM_HOLD_MAX_MS || wb_dat_i[31:10] != 22'h0) ?
                        `CCM_HOLD_MAX_MS : wb_dat_i[9:0];
                end
                `CCM_OFF_ENTRY_SEL: next_st.entry_sel = wb_dat_i[3:0];
                `CCM_OFF_ENTRY_A: next_st.entries[ix].val_a = merge_sel(st.entries[ix].val_a, wb_dat_i, wb_sel_i);
                `CCM_OFF_ENTRY_B: next_st.entries[ix].val_b = merge_sel(st.entries[ix].val_b, wb_dat_i, wb_sel_i);
                `CCM_OFF_INC_SET: next_st.entries[ix].inc_set = 16'(merge_sel({16'h0000, st.entries[ix].inc_set},
                    wb_dat_i, wb_sel_i));
                `CCM_OFF_INC_RST: next_st.entries[ix].inc_rst = 16'(merge_sel({16'h0000, st.entries[ix].inc_rst},
                    wb_dat_i, wb_sel_i));
                `CCM_OFF_DEC_SET: next_st.entries[ix].dec_set = 16'(merge_sel({16'h0000, st.entries[ix].dec_set},
                    wb_dat_i, wb_sel_i));
                `CCM_OFF_DEC_RST: next_st.entries[ix].dec_rst = 16'(merge_sel({16'h0000, st.entries[ix].dec_rst},
                    wb_dat_i, wb_sel_i));
                default: next_st.ack = bus_req; // Unmapped or read-only: acknowledged, no effect.
            endcase
        end

        // Register reads. The stored preset has no entry in this map.
        case (wb_adr_i)
            `CCM_OFF_CTRL:
            begin
                rd[`CCM_CTRL_MODE_BIT] = st.mode;
                rd[`CCM_CTRL_NUM_MSB:`CCM_CTRL_NUM_LSB] = st.num_used;
                rd[`CCM_CTRL_OUT0_MSB:`CCM_CTRL_OUT0_LSB] = st.out0_sel;
                rd[`CCM_CTRL_OUT1_MSB:`CCM_CTRL_OUT1_LSB] = st.out1_sel;
            end
            `CCM_OFF_COUNT: rd = st.count;
            `CCM_OFF_TEMP_CUR: rd = st.temp_cur;
            `CCM_OFF_TEMP_PRE: rd = st.temp_pre;
            `CCM_OFF_STATUS:
            begin
                rd[15:0] = st.flags;
                rd[`CCM_STAT_OUT0_BIT] = ext_out0;
                rd[`CCM_STAT_OUT1_BIT] = ext_out1;
            end
            `CCM_OFF_HOLD: rd[9:0] = st.hold_ms;
            `CCM_OFF_ENTRY_SEL: rd[3:0] = st.entry_sel;
            `CCM_OFF_ENTRY_A: rd = st.entries[ix].val_a;
            `CCM_OFF_ENTRY_B: rd = st.entries[ix].val_b;
            `CCM_OFF_INC_SET: rd[15:0] = st.entries[ix].inc_set;
            `CCM_OFF_INC_RST: rd[15:0] = st.entries[ix].inc_rst;
            `CCM_OFF_DEC_SET: rd[15:0] = st.entries[ix].dec_set;
            `CCM_OFF_DEC_RST: rd[15:0] = st.entries[ix].dec_rst;
            default: rd = `CCM_RST_WORD;
        endcase
        next_st.rdata = (bus_req && !wb_we_i) ? rd : `CCM_RST_WORD;

        // Count value. Only a step, a current-value change request or a preset
        // load moves it; the request bits are write-one pulses and read as zero.
        if (count_step)
        begin
            next_st.count = count_up ? st.count + 32'h0000_0001 : st.count - 32'h0000_0001;
        end
        if (preset_load)
        begin
            next_st.count = st.preset;
        end
        if (bus_wr && wb_adr_i == `CCM_OFF_REQUEST && wb_sel_i[0])
        begin
            if (wb_dat_i[`CCM_REQ_CUR_BIT])
            begin
                next_st.count = st.temp_cur;
            end
            if (wb_dat_i[`CCM_REQ_PRE_BIT])
            begin
                next_st.preset = st.temp_pre;
            end
        end

        // The step is remembered for one cycle so the match is taken on the
        // value it produced, with the direction that produced it. A step that
        // a preset load or a current-value request overrides is not matched.
        next_st.step_seen = count_step && !preset_load
            && !(bus_wr && wb_adr_i == `CCM_OFF_REQUEST && wb_sel_i[0] && wb_dat_i[`CCM_REQ_CUR_BIT]);
        next_st.step_up = count_up;

        // Comparison. Entries are walked from 15 down to 0 so that the lowest
        // index is applied last and wins any conflict.
        if (st.mode == MODE_TARGET)
        begin
            if (st.step_seen)
            begin
                for (int i = `CCM_NUM_ENTRIES - 1; i >= 0; i--)
                begin
                    if (5'(i) < st.num_used && st.count == st.entries[i].val_a)
                    begin
                        if (st.step_up)
                        begin
                            fl = apply_pat(fl, st.entries[i].inc_set, st.entries[i].inc_rst);
                        end
                        else
                        begin
                            fl = apply_pat(fl, st.entries[i].dec_set, st.entries[i].dec_rst);
                        end
                    end
                end
            end
            // Without a match the flags keep whatever the last action left.
        end
        else
        begin
            // Band flags are rebuilt every cycle from the current count, so the
            // direction plays no part; flags no active band touches read OFF.
            fl = `CCM_RST_FLAGS;
            for (int i = `CCM_NUM_ENTRIES - 1; i >= 0; i--)
            begin
                if (5'(i) < st.num_used && in_band(st.count, st.entries[i].val_a, st.entries[i].val_b))
                begin
                    fl = apply_pat(fl, st.entries[i].inc_set, st.entries[i].inc_rst);
                end
            end
        end
        next_st.flags = fl;

        // External output sources; the hold stage adds the band-only stretch.
        next_st.src0 = out_src(st.out0_sel, st.flags);
        next_st.src1 = out_src(st.out1_sel, st.flags);

        // Millisecond tick for the hold countdown.
        next_st.ms_tick = 1'b0;
        if (st.ms_div >= MS_LAST)
        begin
            next_st.ms_div = `CCM_RST_WORD;
            next_st.ms_tick = 1'b1;
        end
        else
        begin
            next_st.ms_div = st.ms_div + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Clearing the whole struct gives count zero, target mode, no hold, and
    // both external outputs set to not output.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.num_used <= `CCM_NUM_RESET;
            st.out0_sel <= `CCM_OUTSEL_NONE;
            st.out1_sel <= `CCM_OUTSEL_NONE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // External output hold stages
    // ------------------------------------------------------------------------
    // Hold is enabled only in band mode; in target mode the outputs follow the flag.
    output_hold hold0 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ms_tick(st.ms_tick),
        .src(st.src0),
        .hold_en(hold_en),
        .hold_ms(st.hold_ms),
        .out(ext_out0)
    );

    output_hold hold1 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ms_tick(st.ms_tick),
        .src(st.src1),
        .hold_en(hold_en),
        .hold_ms(st.hold_ms),
        .out(ext_out1)
    );

    // ------------------------------------------------------------------------
    // Outputs taken straight from state flip-flops
    // ------------------------------------------------------------------------
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign live_counter_value = st.count;
    assign match_flags = st.flags;

endmodule

`default_nettype wire

// File: sim/ccm_checker_assertions.sv
`include "ccm_consts.svh"
`default_nettype none

// ----
// Port-level checker for the comparison block.
// ----
module ccm_checker #(
    parameter int MS_CYCLES = 4
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic count_step,
    input wire logic count_up,
    input wire logic preset_load,
    input wire logic [31:0] live_counter_value,
    input wire logic [15:0] match_flags,
    input wire logic ext_out0,
    input wire logic ext_out1
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // A write is taken on the edge where the request is up and ack is still low.
    wire taken_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    chk_count_zero: assert property ($fell(sys_rst) |-> live_counter_value == 32'h0)
        else $error("count not zero after reset");
    chk_outs_idle: assert property ($fell(sys_rst) |-> !ext_out0 && !ext_out1)
        else $error("external outputs active after reset");
    chk_count_ro: assert property (taken_wr && wb_adr_i == `CCM_OFF_COUNT && !count_step && !preset_load
        |=> $stable(live_counter_value)) else $error("count changed by a direct write");
    chk_step_dir: assert property (count_step && !preset_load && !taken_wr
        |=> live_counter_value == $past(live_counter_value) + ($past(count_up) ? 32'h1 : 32'hFFFF_FFFF))
        else $error("count step wrong");
    chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    // Flags move only after a count change or a recent configuration write.
    chk_flags_cause: assert property ($changed(match_flags) |->
        $past(live_counter_value) != $past(live_counter_value, 2) || $past(wb_we_i, 2) || $past(wb_we_i, 3))
        else $error("flags changed without cause");
    chk_out0_src: assert property ($rose(ext_out0) |-> $past(match_flags[0], 2) || $past(match_flags[1], 2))
        else $error("output 0 rose without flag 0 or 1");
    chk_out1_src: assert property ($rose(ext_out1) |-> $past(match_flags[0], 2) || $past(match_flags[1], 2))
        else $error("output 1 rose without flag 0 or 1");

    cover property (count_step ##2 $changed(match_flags));
    cover property ($fell(match_flags[0]) ##2 ext_out0);
    cover property (taken_wr && wb_adr_i == `CCM_OFF_COUNT);
endmodule

bind counter_compare_match ccm_checker #(
    .MS_CYCLES(MS_CYCLES)
) u_chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .count_step(count_step),
    .count_up(count_up),
    .preset_load(preset_load),
    .live_counter_value(live_counter_value),
    .match_flags(match_flags),
    .ext_out0(ext_out0),
    .ext_out1(ext_out1)
);

`default_nettype wire

// File: sim/testbench.sv
`include "ccm_consts.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic count_step = 0, count_up = 0, preset_load = 0, ext_out0, ext_out1;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, live_counter_value, rd;
    logic [15:0] match_flags;
    int errors = 0, samples_checked = 0, i;
    typedef struct packed { logic up; logic [31:0] cnt; logic [15:0] flg; } row_s;
    row_s rows [8];

    // A short millisecond keeps the hold test within a few dozen cycles.
    counter_compare_match #(
        .MS_CYCLES(4)
    ) u_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .count_step(count_step),
        .count_up(count_up),
        .preset_load(preset_load),
        .live_counter_value(live_counter_value),
        .match_flags(match_flags),
        .ext_out0(ext_out0),
        .ext_out1(ext_out1)
    );

    // 40 MHz clock.
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ----
    // Tasks
    // ----
    task automatic summarize();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic Wishbone cycle; read data lands in rd at the ack edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hF, dat};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (n >= 20)
        begin
            errors++;
            summarize();
        end
    endtask

    // Step once, then wait for flags and both output stages to settle.
    task automatic step(input logic up);
        @(posedge core_clk);
        {count_step, count_up} <= {1'b1, up};
        @(posedge core_clk);
        count_step <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic entry(input logic [3:0] idx, input logic [31:0] a, b, input logic [15:0] s0, r0, s1, r1);
        wb(1, `CCM_OFF_ENTRY_SEL, {28'h0, idx});
        wb(1, `CCM_OFF_ENTRY_A, a);
        wb(1, `CCM_OFF_ENTRY_B, b);
        wb(1, `CCM_OFF_INC_SET, {16'h0, s0});
        wb(1, `CCM_OFF_INC_RST, {16'h0, r0});
        wb(1, `CCM_OFF_DEC_SET, {16'h0, s1});
        wb(1, `CCM_OFF_DEC_RST, {16'h0, r1});
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        rows = '{'{1, 1, 0}, '{1, 2, 0}, '{1, 3, 3}, '{1, 4, 1},
                 '{0, 3, 0}, '{0, 2, 16'h8000}, '{0, 1, 16'h8000}, '{1, 2, 16'h8000}};
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check("count", 32'h0, live_counter_value);
        check("outs", 32'h0, {30'h0, ext_out1, ext_out0});
        wb(0, `CCM_OFF_CTRL, 0);
        check("ctrl", 32'h0000_0100, rd);
        // Staged preset, request, then the load pulse adopts it.
        wb(1, `CCM_OFF_TEMP_PRE, 32'h64);
        wb(0, `CCM_OFF_TEMP_PRE, 0);
        check("temp_pre", 32'h64, rd);
        wb(1, `CCM_OFF_REQUEST, 32'h2);
        @(posedge core_clk);
        preset_load <= 1'b1;
        @(posedge core_clk);
        preset_load <= 1'b0;
        @(posedge core_clk);
        check("count", 32'h64, live_counter_value);
        wb(1, `CCM_OFF_COUNT, 32'h55);
        wb(0, `CCM_OFF_COUNT, 0);
        check("count", 32'h64, rd);
        wb(0, `CCM_OFF_REQUEST, 0);
        check("request", 32'h0, rd);
        wb(0, 8'h40, 0);
        check("unmapped", 32'h0, rd);
        wb(1, `CCM_OFF_TEMP_CUR, 32'h0);
        wb(1, `CCM_OFF_REQUEST, 32'h1);
        // Unsorted targets, a conflict at 3 that entry 0 must win, direction-only entries.
        // Output 0 carries flag 1 and output 1 carries flag 0.
        wb(1, `CCM_OFF_CTRL, 32'h6040);
        entry(0, 3, 0, 16'h0003, 0, 0, 16'h0001);
        entry(1, 2, 0, 0, 0, 16'h8000, 0);
        entry(2, 3, 0, 0, 16'h0001, 0, 0);
        entry(3, 4, 0, 0, 16'h0002, 0, 0);
        for (i = 0; i < 8; i++)
        begin
            step(rows[i].up);
            check("count", rows[i].cnt, live_counter_value);
            check("flags", {16'h0, rows[i].flg}, {16'h0, match_flags});
            check("ext_out0", {31'h0, rows[i].flg[1]}, {31'h0, ext_out0});
            check("ext_out1", {31'h0, rows[i].flg[0]}, {31'h0, ext_out1});
        end
        wb(1, `CCM_OFF_CTRL, 32'h2000);
        step(1);
        check("flags", 32'h8000, {16'h0, match_flags});
        // Band mode with a hold on both outputs; limits inclusive.
        wb(1, `CCM_OFF_HOLD, 32'h7FF);
        wb(0, `CCM_OFF_HOLD, 0);
        check("hold", 32'h3E8, rd);
        wb(1, `CCM_OFF_HOLD, 32'h2);
        // Both outputs carry flag 0 here, so both hold stages are exercised.
        wb(1, `CCM_OFF_CTRL, 32'h5011);
        entry(0, 10, 12, 16'h0001, 0, 0, 0);
        wb(1, `CCM_OFF_TEMP_CUR, 32'h9);
        wb(1, `CCM_OFF_REQUEST, 32'h1);
        step(1);
        check("flags", 32'h1, {16'h0, match_flags});
        check("ext_out0", 32'h1, {31'h0, ext_out0});
        check("ext_out1", 32'h1, {31'h0, ext_out1});
        wb(0, `CCM_OFF_STATUS, 0);
        check("status", 32'h0003_0001, rd);
        repeat (3) step(1);
        check("flags", 32'h0, {16'h0, match_flags});
        check("ext_out0", 32'h1, {31'h0, ext_out0});
        check("ext_out1", 32'h1, {31'h0, ext_out1});
        repeat (20) @(posedge core_clk);
        check("ext_out0", 32'h0, {31'h0, ext_out0});
        check("ext_out1", 32'h0, {31'h0, ext_out1});
        step(0);
        check("flags", 32'h1, {16'h0, match_flags});
        // Second reset in mid-run.
        sys_rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check("count", 32'h0, live_counter_value);
        check("flags", 32'h0, {16'h0, match_flags});
        summarize();
    end
endmodule

`default_nettype wire
